// >>> accumulator_arith_datapath.sv
// Arithmetic execution and operand addressing for an 8-bit accumulator core
//
// What this block does
// - Direct mode addresses RAM/special registers by byte.
// - Indirect uses pointer register; data pointer is 16-bit.
// - Register mode picks one of eight bank registers.
// - Implied accumulator operands; immediate value from instruction.
// - Indexed reads program memory at pointer plus accumulator.
// - Bit mode picks one of 256 bits.
// - Add lengths: register 1/1, indirect 2, direct/immediate 2/2.
// - Add-with-carry includes carry, same lengths as add.
// - Subtract-with-borrow: register 1 cycle, others 2.
// - Increment: accumulator 1, register 2, memory 3 cycles.
// - Decrement: accumulator 1, register 2, memory 3 cycles.
// - Data pointer increment: whole 16 bits, one cycle.
// - Multiply accumulator by B in 2 cycles.
// - Divide accumulator by B in 6 cycles.
// - Decimal adjust accumulator in 3 cycles.
`timescale 1ns/100ps
`default_nettype none

module accumulator_arith_datapath
   import arith_datapath_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Command handshake
   input wire logic cmd_valid_i,
   input wire cmd_type cmd_i,
   output logic cmd_ready_o,
   output logic done_o,
   output logic [1:0] instr_bytes_o,
   // Register bank select from the status word
   input wire logic [1:0] bank_sel_i,
   // State loads from other execution units
   input wire load_type load_i,
   // Internal RAM and special register port, read in the same cycle
   output logic [7:0] mem_addr_o,
   output logic mem_wr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   // Program memory port, read in the same cycle
   output logic [15:0] code_addr_o,
   input wire logic [7:0] code_rdata_i,
   // Architectural state
   output logic [7:0] acc_o,
   output logic [7:0] b_o,
   output flags_type flags_o,
   output logic parity_o,
   output logic [15:0] data_pointer_reg_o,
   output logic bit_value_o
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } state_type;

   state_type state, next_state;
   logic [2:0] cnt, next_cnt;
   logic [2:0] len, next_len;
   cmd_type cmd_q, next_cmd_q;
   logic [1:0] instr_bytes, next_instr_bytes;
   logic [7:0] ptr, next_ptr;
   logic [7:0] opnd_q, next_opnd_q;
   logic [7:0] acc, next_acc;
   logic [7:0] b, next_b;
   flags_type flags, next_flags;
   logic parity, next_parity;
   logic [15:0] data_pointer_reg, next_data_pointer_reg;
   logic [15:0] code_addr, next_code_addr;
   logic bit_value, next_bit_value;

   logic [7:0] alu_operand;
   logic [7:0] alu_acc;
   logic [7:0] alu_b;
   flags_type alu_flags;
   logic [7:0] alu_step;
   logic is_step;
   logic last_cycle;
   logic [7:0] bit_byte_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Length tables

   // Execution cycles per operation and addressing form
   function automatic logic [2:0] cycle_len(input cmd_type c);
      begin
         case (c.op)
            OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
               cycle_len = (c.mode == MODE_BANK_REG) ? LEN_ARITH_REG : LEN_ARITH_MEM;
            end
            OP_INCREMENT, OP_DECREMENT: begin
               case (c.mode)
                  MODE_ACC: cycle_len = LEN_STEP_ACC;
                  MODE_BANK_REG: cycle_len = LEN_STEP_REG;
                  default: cycle_len = LEN_STEP_MEM;
               endcase
            end
            OP_INC_DATA_POINTER: cycle_len = LEN_INC_DATA_POINTER;
            OP_MULTIPLY: cycle_len = LEN_MULTIPLY;
            OP_DIVIDE: cycle_len = LEN_DIVIDE;
            OP_DECIMAL_ADJUST: cycle_len = LEN_DECIMAL_ADJUST;
            OP_BIT_READ: cycle_len = LEN_BIT_READ;
            default: cycle_len = LEN_CODE_INDEX;
         endcase
      end
   endfunction

   // Instruction bytes, so the fetch logic can step past the operand
   function automatic logic [1:0] byte_len(input cmd_type c);
      begin
         case (c.op)
            OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
               byte_len = ((c.mode == MODE_DIRECT) || (c.mode == MODE_IMMEDIATE)) ? BYTES_TWO : BYTES_ONE;
            end
            OP_INCREMENT, OP_DECREMENT: begin
               byte_len = (c.mode == MODE_DIRECT) ? BYTES_TWO : BYTES_ONE;
            end
            OP_BIT_READ: byte_len = BYTES_TWO;
            default: byte_len = BYTES_ONE;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Operand addressing

   // Lower bit space lives in RAM, upper half in byte-aligned special registers
   assign bit_byte_addr = cmd_q.operand_byte[7] ? (cmd_q.operand_byte & BIT_SPECIAL_MASK)
                        : (BIT_RAM_BASE + {4'h0, cmd_q.operand_byte[6:3]});

   // Address is combinational so a one-cycle form can read and commit at once
   always_comb begin
      mem_addr_o = 8'h00;
      if (state == ST_RUN) begin
         if (cmd_q.op == OP_BIT_READ) begin
            mem_addr_o = bit_byte_addr;
         end else begin
            case (cmd_q.mode)
               MODE_BANK_REG: mem_addr_o = {3'b000, bank_sel_i, cmd_q.reg_sel};
               MODE_DIRECT: mem_addr_o = cmd_q.operand_byte;
               MODE_INDIRECT: begin
                  // First cycle fetches the pointer register itself
                  mem_addr_o = (cnt == CNT_FIRST) ? {3'b000, bank_sel_i, 2'b00, cmd_q.reg_sel[0]} : ptr;
               end
               default: mem_addr_o = 8'h00;
            endcase
         end
      end
   end

   // Operand source for the arithmetic unit
   always_comb begin
      case (cmd_q.mode)
         MODE_ACC: alu_operand = acc;
         MODE_IMMEDIATE: alu_operand = cmd_q.operand_byte;
         default: alu_operand = is_step ? opnd_q : mem_rdata_i;
      endcase
   end

   assign is_step = (cmd_q.op == OP_INCREMENT) || (cmd_q.op == OP_DECREMENT);
   assign last_cycle = (state == ST_RUN) && (cnt == len);

   arith_unit u_arith (
      .op_i(cmd_q.op),
      .acc_i(acc),
      .b_i(b),
      .operand_i(alu_operand),
      .flags_i(flags),
      .acc_o(alu_acc),
      .b_o(alu_b),
      .flags_o(alu_flags),
      .step_o(alu_step)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and architectural state, next values
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_len = len;
      next_cmd_q = cmd_q;
      next_instr_bytes = instr_bytes;
      next_ptr = ptr;
      next_opnd_q = opnd_q;
      next_acc = acc;
      next_b = b;
      next_flags = flags;
      next_data_pointer_reg = data_pointer_reg;
      next_code_addr = code_addr;
      next_bit_value = bit_value;
      // Loads from other units yield to a commit in the same cycle
      if (load_i.acc_we) next_acc = load_i.acc;
      if (load_i.b_we) next_b = load_i.b;
      if (load_i.dp_we) next_data_pointer_reg = load_i.dp;
      if (load_i.carry_we) next_flags.carry = load_i.carry;
      case (state)
         ST_IDLE: begin
            if (cmd_valid_i) begin
               next_state = ST_RUN;
               next_cnt = CNT_FIRST;
               next_len = cycle_len(cmd_i);
               next_cmd_q = cmd_i;
               next_instr_bytes = byte_len(cmd_i);
               next_code_addr = data_pointer_reg + {8'h00, acc};
            end
         end
         ST_RUN: begin
            if ((cmd_q.mode == MODE_INDIRECT) && (cnt == CNT_FIRST)) begin
               next_ptr = mem_rdata_i;
            end
            // Read-modify-write forms capture the byte one cycle before writing
            if (cnt == len - CNT_FIRST) begin
               next_opnd_q = mem_rdata_i;
            end
            if (cnt == len) begin
               next_state = ST_IDLE;
               case (cmd_q.op)
                  OP_INCREMENT, OP_DECREMENT: begin
                     if (cmd_q.mode == MODE_ACC) begin
                        next_acc = alu_step;
                     end
                  end
                  OP_INC_DATA_POINTER: next_data_pointer_reg = data_pointer_reg + 16'h0001;
                  OP_BIT_READ: next_bit_value = mem_rdata_i[cmd_q.operand_byte[2:0]];
                  OP_CODE_INDEX: next_acc = code_rdata_i;
                  default: begin
                     next_acc = alu_acc;
                     next_b = alu_b;
                     next_flags = alu_flags;
                  end
               endcase
            end else begin
               next_cnt = cnt + CNT_FIRST;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_parity = ^next_acc;
   end

   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         cnt <= 3'h0;
         len <= 3'h0;
         cmd_q <= '0;
         instr_bytes <= 2'h0;
         ptr <= 8'h00;
         opnd_q <= 8'h00;
         acc <= 8'h00;
         b <= 8'h00;
         flags <= '0;
         parity <= 1'b0;
         data_pointer_reg <= 16'h0000;
         code_addr <= 16'h0000;
         bit_value <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         len <= next_len;
         cmd_q <= next_cmd_q;
         instr_bytes <= next_instr_bytes;
         ptr <= next_ptr;
         opnd_q <= next_opnd_q;
         acc <= next_acc;
         b <= next_b;
         flags <= next_flags;
         parity <= next_parity;
         data_pointer_reg <= next_data_pointer_reg;
         code_addr <= next_code_addr;
         bit_value <= next_bit_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign cmd_ready_o = (state == ST_IDLE);
   assign done_o = last_cycle;
   assign mem_wr_o = last_cycle && is_step && (cmd_q.mode != MODE_ACC);
   assign mem_wdata_o = alu_step;
   assign instr_bytes_o = instr_bytes;
   assign code_addr_o = code_addr;
   assign acc_o = acc;
   assign b_o = b;
   assign flags_o = flags;
   assign parity_o = parity;
   assign data_pointer_reg_o = data_pointer_reg;
   assign bit_value_o = bit_value;

endmodule // accumulator_arith_datapath

`default_nettype wire

// >>> arith_datapath_pkg.sv
// Shared types and constants for the accumulator arithmetic datapath
package arith_datapath_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Operations and operand addressing modes
   typedef enum logic [3:0] {
      OP_ADD = 4'h0,
      OP_ADD_WITH_CARRY = 4'h1,
      OP_SUBTRACT_WITH_BORROW = 4'h2,
      OP_INCREMENT = 4'h3,
      OP_DECREMENT = 4'h4,
      OP_INC_DATA_POINTER = 4'h5,
      OP_MULTIPLY = 4'h6,
      OP_DIVIDE = 4'h7,
      OP_DECIMAL_ADJUST = 4'h8,
      OP_BIT_READ = 4'h9,
      OP_CODE_INDEX = 4'hA
   } arith_op_type;

   typedef enum logic [2:0] {
      MODE_ACC = 3'h0,
      MODE_BANK_REG = 3'h1,
      MODE_DIRECT = 3'h2,
      MODE_INDIRECT = 3'h3,
      MODE_IMMEDIATE = 3'h4
   } addr_mode_type;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      arith_op_type op;
      addr_mode_type mode;
      logic [2:0] reg_sel;      // Bank register, or pointer register in bit 0
      logic [7:0] operand_byte; // Direct address, immediate value or bit address
   } cmd_type;

   typedef struct packed {
      logic carry;
      logic aux_carry;
      logic overflow;
   } flags_type;

   typedef struct packed {
      logic acc_we;
      logic [7:0] acc;
      logic b_we;
      logic [7:0] b;
      logic dp_we;
      logic [15:0] dp;
      logic carry_we;
      logic carry;
   } load_type;

   ////////////////////////////////////////////////////////////////////////////
   // Execution lengths in cycles
   localparam logic [2:0] LEN_ARITH_REG = 3'h1;
   localparam logic [2:0] LEN_ARITH_MEM = 3'h2;
   localparam logic [2:0] LEN_STEP_ACC = 3'h1;
   localparam logic [2:0] LEN_STEP_REG = 3'h2;
   localparam logic [2:0] LEN_STEP_MEM = 3'h3;
   localparam logic [2:0] LEN_INC_DATA_POINTER = 3'h1;
   localparam logic [2:0] LEN_MULTIPLY = 3'h2;
   localparam logic [2:0] LEN_DIVIDE = 3'h6;
   localparam logic [2:0] LEN_DECIMAL_ADJUST = 3'h3;
   localparam logic [2:0] LEN_BIT_READ = 3'h2;
   localparam logic [2:0] LEN_CODE_INDEX = 3'h5;
   localparam logic [2:0] CNT_FIRST = 3'h1;

   // Instruction lengths in bytes
   localparam logic [1:0] BYTES_ONE = 2'h1;
   localparam logic [1:0] BYTES_TWO = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Bit space and decimal correction
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;
   localparam logic [7:0] BIT_SPECIAL_MASK = 8'hF8;
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [7:0] BCD_FIX_LO = 8'h06;
   localparam logic [7:0] BCD_FIX_HI = 8'h60;

endpackage

// >>> arith_unit.sv
// Combinational arithmetic unit: add, subtract, step, multiply, divide, decimal adjust
`timescale 1ns/100ps
`default_nettype none

module arith_unit
   import arith_datapath_pkg::*;
(
   // Operation and operands
   input wire arith_op_type op_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] b_i,
   input wire logic [7:0] operand_i,
   input wire flags_type flags_i,
   // Results
   output logic [7:0] acc_o,
   output logic [7:0] b_o,
   output flags_type flags_o,
   output logic [7:0] step_o
);

   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [8:0] diff;
   logic [4:0] low_diff;
   logic [15:0] product;
   logic [8:0] adj;
   logic cin;

   ////////////////////////////////////////////////////////////////////////////
   // Result selection
   always_comb begin
      acc_o = acc_i;
      b_o = b_i;
      flags_o = flags_i;
      cin = (op_i == OP_ADD_WITH_CARRY) ? flags_i.carry : 1'b0;
      sum = {1'b0, acc_i} + {1'b0, operand_i} + {8'h00, cin};
      low_sum = {1'b0, acc_i[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, cin};
      diff = {1'b0, acc_i} - {1'b0, operand_i} - {8'h00, flags_i.carry};
      low_diff = {1'b0, acc_i[3:0]} - {1'b0, operand_i[3:0]} - {4'h0, flags_i.carry};
      product = acc_i * b_i;
      adj = {1'b0, acc_i};
      step_o = (op_i == OP_DECREMENT) ? operand_i - 8'h01 : operand_i + 8'h01;
      case (op_i)
         OP_ADD, OP_ADD_WITH_CARRY: begin
            acc_o = sum[7:0];
            flags_o.carry = sum[8];
            flags_o.aux_carry = low_sum[4];
            flags_o.overflow = (acc_i[7] == operand_i[7]) && (sum[7] != acc_i[7]);
         end
         OP_SUBTRACT_WITH_BORROW: begin
            acc_o = diff[7:0];
            flags_o.carry = diff[8];
            flags_o.aux_carry = low_diff[4];
            flags_o.overflow = (acc_i[7] != operand_i[7]) && (diff[7] != acc_i[7]);
         end
         OP_MULTIPLY: begin
            acc_o = product[7:0];
            b_o = product[15:8];
            flags_o.carry = 1'b0;
            flags_o.overflow = (product[15:8] != 8'h00);
         end
         OP_DIVIDE: begin
            flags_o.carry = 1'b0;
            // Zero divisor leaves both registers untouched
            if (b_i == 8'h00) begin
               flags_o.overflow = 1'b1;
            end else begin
               acc_o = acc_i / b_i;
               b_o = acc_i % b_i;
               flags_o.overflow = 1'b0;
            end
         end
         OP_DECIMAL_ADJUST: begin
            // Low digit first, its carry may ripple into the high digit
            if ((acc_i[3:0] > BCD_DIGIT_MAX) || flags_i.aux_carry) begin
               adj = {1'b0, acc_i} + {1'b0, BCD_FIX_LO};
            end
            if ((adj[7:4] > BCD_DIGIT_MAX) || adj[8] || flags_i.carry) begin
               adj = adj + {1'b0, BCD_FIX_HI};
            end
            acc_o = adj[7:0];
            flags_o.carry = flags_i.carry | adj[8];
         end
         default: begin
            acc_o = acc_i;
         end
      endcase
   end

endmodule // arith_unit

`default_nettype wire

// >>> arith_datapath_properties.sv
// Checker of timing and result relations at the datapath ports
`timescale 1ns/100ps
`default_nettype none

module arith_datapath_checker
   import arith_datapath_pkg::*;
(
   // Clock, reset and command
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic cmd_valid_i,
   input wire cmd_type cmd_i,
   // Observed outputs
   input wire logic cmd_ready_o,
   input wire logic done_o,
   input wire logic mem_wr_o,
   input wire logic [15:0] code_addr_o,
   input wire logic [7:0] acc_o,
   input wire logic parity_o,
   input wire logic [15:0] data_pointer_reg_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the accepted command
   wire logic take = cmd_valid_i && cmd_ready_o;
   wire logic arith = cmd_i.op inside {OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW};
   wire logic step_mem = cmd_i.op inside {OP_INCREMENT, OP_DECREMENT} && cmd_i.mode inside {MODE_DIRECT, MODE_INDIRECT};

   property p_busy; take |=> !cmd_ready_o; endproperty
   a_busy: assert property (p_busy) else $error("ready high after accept");
   property p_ready_back; done_o |=> cmd_ready_o; endproperty
   a_ready_back: assert property (p_ready_back) else $error("ready not back after done");
   property p_arith_reg; take && arith && cmd_i.mode == MODE_BANK_REG |=> done_o; endproperty
   a_arith_reg: assert property (p_arith_reg) else $error("register form not one cycle");
   property p_arith_mem;
      take && arith && cmd_i.mode inside {MODE_DIRECT, MODE_INDIRECT, MODE_IMMEDIATE} |=> !done_o ##1 done_o;
   endproperty
   a_arith_mem: assert property (p_arith_mem) else $error("memory form not two cycles");
   property p_step_mem; take && step_mem |=> (!done_o)[*2] ##1 (done_o && mem_wr_o); endproperty
   a_step_mem: assert property (p_step_mem) else $error("memory step not three cycles");
   property p_wr_done; mem_wr_o |-> done_o; endproperty
   a_wr_done: assert property (p_wr_done) else $error("write outside last cycle");
   property p_dp_inc;
      take && cmd_i.op == OP_INC_DATA_POINTER |=> done_o ##1 data_pointer_reg_o == $past(data_pointer_reg_o, 2) + 16'h0001;
   endproperty
   a_dp_inc: assert property (p_dp_inc) else $error("pointer step wrong");
   property p_product; take && cmd_i.op == OP_MULTIPLY |=> !done_o ##1 done_o; endproperty
   a_product: assert property (p_product) else $error("multiply not two cycles");
   property p_div; take && cmd_i.op == OP_DIVIDE |=> (!done_o)[*5] ##1 done_o; endproperty
   a_div: assert property (p_div) else $error("divide not six cycles");
   property p_da; take && cmd_i.op == OP_DECIMAL_ADJUST |=> (!done_o)[*2] ##1 done_o; endproperty
   a_da: assert property (p_da) else $error("adjust not three cycles");
   property p_parity; parity_o == ^acc_o; endproperty
   a_parity: assert property (p_parity) else $error("parity mismatch");
   property p_index;
      take && cmd_i.op == OP_CODE_INDEX |=> code_addr_o == $past(data_pointer_reg_o) + $past(acc_o);
   endproperty
   a_index: assert property (p_index) else $error("code address wrong");

   // Main scenarios reached
   c_div: cover property (take && cmd_i.op == OP_DIVIDE);
   c_step_mem: cover property (take && step_mem);
   c_index: cover property (take && cmd_i.op == OP_CODE_INDEX);
endmodule // arith_datapath_checker

bind accumulator_arith_datapath arith_datapath_checker u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
   .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .mem_wr_o(mem_wr_o),
   .code_addr_o(code_addr_o), .acc_o(acc_o), .parity_o(parity_o), .data_pointer_reg_o(data_pointer_reg_o));

`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the accumulator arithmetic datapath
`timescale 1ns/100ps
`default_nettype none

module tb_top
   import arith_datapath_pkg::*;
;
   logic clk_sys_i, reset_i, cmd_valid_i, cmd_ready_o, done_o, mem_wr_o, parity_o, bit_value_o;
   logic [1:0] bank_sel_i, instr_bytes_o, bank;
   logic [7:0] mem_addr_o, mem_wdata_o, mem_rdata_i, code_rdata_i, acc_o, b_o;
   logic [15:0] code_addr_o, data_pointer_reg_o;
   logic [7:0] mem [256];
   logic [31:0] rv;
   cmd_type cmd_i;
   load_type load_i;
   flags_type flags_o;
   int n_mismatch, samples_checked, m_acc, m_b, m_dp;
   bit m_cy, m_ac, m_ov, m_bit;
   arith_op_type aops[3] = '{OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW};
   addr_mode_type modes[5] = '{MODE_BANK_REG, MODE_DIRECT, MODE_INDIRECT, MODE_IMMEDIATE, MODE_ACC};

   accumulator_arith_datapath uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .instr_bytes_o(instr_bytes_o),
      .bank_sel_i(bank_sel_i), .load_i(load_i), .mem_addr_o(mem_addr_o), .mem_wr_o(mem_wr_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .code_addr_o(code_addr_o),
      .code_rdata_i(code_rdata_i), .acc_o(acc_o), .b_o(b_o), .flags_o(flags_o), .parity_o(parity_o),
      .data_pointer_reg_o(data_pointer_reg_o), .bit_value_o(bit_value_o));

   ////////////////////////////////////////////////////////////////////////////
   // Clock, combinational RAM and a program memory whose byte is a hash of its address
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   assign mem_rdata_i = mem[mem_addr_o];
   assign code_rdata_i = code_addr_o[7:0] ^ code_addr_o[15:8] ^ 8'h5A;
   always @(posedge clk_sys_i) if (mem_wr_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;

   task automatic chk(input string nm, input int e, input logic [15:0] g);
      samples_checked++;
      if (g !== e[15:0]) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e[15:0], g);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // State load through the side port, mirrored in the model
   task automatic load(input int a, input int b, input int dp, input int c);
      @(posedge clk_sys_i);
      load_i <= '{1'b1, a[7:0], 1'b1, b[7:0], 1'b1, dp[15:0], 1'b1, c[0]};
      @(posedge clk_sys_i);
      load_i <= '0;
      m_acc = a % 256;
      m_b = b % 256;
      m_dp = dp % 65536;
      m_cy = c[0];
   endtask

   // One command: model first, then drive, then compare timing and results
   task automatic run(input arith_op_type op, input addr_mode_type md, input logic [2:0] rs,
                      input logic [7:0] ob, input bit hold);
      int a, o, c, r, len, nb, tgt, n, eo, ea;
      if (md == MODE_DIRECT) ob[7] = 1'b0; // Keep direct reads in plain RAM
      tgt = md == MODE_BANK_REG ? {3'h0, bank, rs} : md == MODE_DIRECT ? ob : mem[{3'h0, bank, 2'h0, rs[0]}];
      o = md == MODE_IMMEDIATE ? ob : md == MODE_ACC ? m_acc : mem[tgt];
      a = m_acc;
      c = op == OP_ADD ? 0 : m_cy;
      nb = md inside {MODE_DIRECT, MODE_IMMEDIATE} || op == OP_BIT_READ ? 2 : 1;
      len = md == MODE_BANK_REG ? 1 : 2;
      eo = -1;
      ea = (m_dp + a) % 65536;
      case (op)
         OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
            r = op == OP_SUBTRACT_WITH_BORROW ? a - o - c : a + o + c;
            m_cy = r < 0 || r > 255;
            m_ac = op == OP_SUBTRACT_WITH_BORROW ? a % 16 < o % 16 + c : a % 16 + o % 16 + c > 15;
            m_ov = op == OP_SUBTRACT_WITH_BORROW ? ((a ^ o) & (a ^ r) & 128) != 0 : ((a ^ r) & (o ^ r) & 128) != 0;
            m_acc = r & 255;
         end
         OP_INCREMENT, OP_DECREMENT: begin
            r = (op == OP_INCREMENT ? o + 1 : o + 255) & 255;
            len = md == MODE_ACC ? 1 : md == MODE_BANK_REG ? 2 : 3;
            if (md == MODE_ACC) m_acc = r;
            else eo = r;
         end
         OP_INC_DATA_POINTER: begin
            len = 1;
            m_dp = (m_dp + 1) % 65536;
         end
         OP_MULTIPLY: begin
            r = a * m_b;
            m_acc = r % 256;
            m_b = r / 256;
            m_ov = m_b != 0;
            m_cy = 0;
         end
         OP_DIVIDE: begin
            len = 6;
            m_ov = m_b == 0;
            m_cy = 0;
            if (m_b != 0) begin
               m_acc = a / m_b;
               m_b = a % m_b;
            end
         end
         OP_DECIMAL_ADJUST: begin
            len = 3;
            r = a;
            if (r % 16 > 9 || m_ac) r += 6;
            if (r > 255) m_cy = 1;
            r = r % 256;
            if (r / 16 > 9 || m_cy) r += 96;
            if (r > 255) m_cy = 1;
            m_acc = r % 256;
         end
         OP_BIT_READ: m_bit = mem[ob < 128 ? 32 + ob / 8 : ob & 248][ob % 8];
         default: begin
            len = 5;
            m_acc = ea % 256 ^ ea / 256 ^ 90;
         end
      endcase
      @(posedge clk_sys_i);
      bank_sel_i <= bank;
      cmd_valid_i <= 1'b1;
      cmd_i <= '{op, md, rs, ob};
      @(posedge clk_sys_i);
      cmd_valid_i <= hold;
      if (hold) cmd_i <= '{OP_DIVIDE, MODE_ACC, 3'h0, 8'h00}; // Request while busy must be ignored
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (done_o !== 1'b1 && n < 9);
      chk("length", len, n);
      chk("write", eo >= 0, mem_wr_o);
      if (eo >= 0) chk("waddr", tgt, mem_addr_o);
      if (eo >= 0) chk("wdata", eo, mem_wdata_o);
      @(posedge clk_sys_i);
      cmd_valid_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("acc", m_acc, acc_o);
      chk("b", m_b, b_o);
      chk("flags", {m_cy, m_ac, m_ov}, flags_o);
      chk("parity", ^m_acc[7:0], parity_o);
      chk("data_pointer", m_dp, data_pointer_reg_o);
      chk("bytes", nb, instr_bytes_o);
      chk("bit", m_bit, bit_value_o);
      chk("ready", 1, cmd_ready_o);
      if (op == OP_CODE_INDEX) chk("code_addr", ea, code_addr_o);
      if (eo >= 0) chk("mem", eo, mem[tgt]);
      $display("done %s %s", op.name(), md.name());
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog at 20000 cycles, far beyond the several hundred cycles the tests need
   initial begin
      #200000;
      n_mismatch++;
      summarize;
   end

   // Main sequence
   initial begin
      rv = $urandom(32'h401DD57F);
      foreach (mem[i]) mem[i] = 8'($urandom);
      reset_i = 1'b1;
      cmd_valid_i = 1'b0;
      cmd_i = '0;
      bank_sel_i = 2'h0;
      bank = 2'h0;
      load_i = '0;
      repeat (3) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("ready", 1, cmd_ready_o);
      chk("acc", 0, acc_o);
      for (int i = 0; i < 45; i++) begin
         rv = $urandom;
         bank = rv[1:0];
         load(rv[15:8], rv[23:16], 0, rv[31]);
         rv = $urandom;
         run(aops[i % 3], modes[(i / 3) % 5], rv[2:0], rv[15:8], 1'b0);
      end
      for (int i = 0; i < 16; i++) begin
         rv = $urandom;
         bank = rv[1:0];
         load(rv[15:8], 0, 0, 0);
         run(i % 2 ? OP_DECREMENT : OP_INCREMENT, modes[(i / 2 % 4 + 4) % 5], rv[4:2], rv[31:24], 1'b0);
      end
      load(255, 255, 65535, 0);
      run(OP_INC_DATA_POINTER, MODE_ACC, 3'h0, 8'h00, 1'b0);
      run(OP_INCREMENT, MODE_ACC, 3'h0, 8'h00, 1'b0);
      run(OP_DECREMENT, MODE_ACC, 3'h0, 8'h00, 1'b0);
      run(OP_MULTIPLY, MODE_ACC, 3'h0, 8'h00, 1'b0);
      run(OP_DIVIDE, MODE_ACC, 3'h0, 8'h00, 1'b1);
      load(200, 0, 0, 1);
      run(OP_DIVIDE, MODE_ACC, 3'h0, 8'h00, 1'b0);
      for (int i = 0; i < 4; i++) begin
         rv = $urandom;
         load(rv[7:0], rv[15:8], 0, 0);
         run(OP_MULTIPLY, MODE_ACC, 3'h0, 8'h00, 1'b0);
         run(OP_DIVIDE, MODE_ACC, 3'h0, 8'h00, 1'b0);
         load(rv[19:16] % 10 + 16 * (rv[23:20] % 10), 0, 0, 0);
         run(OP_ADD, MODE_IMMEDIATE, 3'h0, 8'(rv[27:24] % 10 + 16 * (rv[31:28] % 10)), 1'b0);
         run(OP_DECIMAL_ADJUST, MODE_ACC, 3'h0, 8'h00, 1'b0);
         run(OP_BIT_READ, MODE_ACC, 3'h0, rv[15:8], 1'b0);
      end
      run(OP_BIT_READ, MODE_ACC, 3'h0, 8'h15, 1'b0);
      run(OP_BIT_READ, MODE_ACC, 3'h0, 8'h9B, 1'b0);
      load(8'h20, 0, 16'h12F0, 0);
      run(OP_CODE_INDEX, MODE_ACC, 3'h0, 8'h00, 1'b0);
      summarize;
   end
endmodule // tb_top

`default_nettype wire
